// ===== smbus_ctrl_pkg.sv
// package for the serial control logic: register layout, timing, states
// assumes a 100 MHz system clock
package smbus_ctrl_pkg;
  localparam logic [7:0] CTRL_OFFSET    = 8'hc0;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam int         BIT_BUSY       = 7;
  localparam int         BIT_ENABLE     = 6;
  localparam int         BIT_START      = 5;
  localparam int         BIT_STOP       = 4;
  localparam int         BIT_EVENT      = 3;
  localparam int         BIT_ACK        = 2;
  localparam int         BIT_FREE_TO    = 1;
  localparam int         BIT_LOW_TO     = 0;
  localparam int         CLK_MHZ        = 100;
  localparam int         START_DELAY_US = 5;
  localparam int         IDLE_FREE_US   = 50;
  localparam int         START_DELAY_CYC = START_DELAY_US * CLK_MHZ;
  localparam int         IDLE_FREE_CYC   = IDLE_FREE_US * CLK_MHZ;
  localparam int         HALF_BIT_CYC    = 500;
  localparam int         CNT_W           = 16;
  localparam logic [7:0] ST_START_SENT  = 8'h08;
  localparam logic [7:0] ST_RESTART     = 8'h10;
  localparam logic [7:0] ST_ADDR_ACK    = 8'h18;
  localparam logic [7:0] ST_DATA_ACK    = 8'h28;
  localparam logic [7:0] ST_SLV_ADDR    = 8'h60;
  localparam logic [7:0] ST_SLV_DATA    = 8'h80;
  localparam logic [7:0] ST_IDLE        = 8'hf8;

  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_t;

  typedef enum logic [5:0] {
    M_IDLE  = 6'b000001,
    M_WAIT  = 6'b000010,
    M_START = 6'b000100,
    M_XFER  = 6'b001000,
    M_STOP  = 6'b010000,
    M_SLAVE = 6'b100000
  } mstate_t;
endpackage

// ===== smbus_control_logic.sv
// control logic of the two-wire serial interface behind its control register
// assumes sfr style byte access from the cpu and open-drain sda/scl pins
`timescale 1ns/1ps
`default_nettype none

module smbus_control_logic
  import smbus_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // special function register access
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  // companion register values
  input  wire logic [7:0] clock_rate_reg_in,
  input  wire logic [7:0] own_address_reg_in,
  input  wire logic [7:0] shift_data_reg_in,
  input  wire logic       irq_enable_in,
  input  wire logic       low_timer_run_in,
  // status and events
  output logic      [7:0] status_code_reg_out,
  output logic      [7:0] rx_data_out,
  output logic            irq_out,
  output logic            low_count_out,
  // bus pins
  input  wire logic       sda_in,
  input  wire logic       scl_in,
  output pin_drive_t      sda_out,
  output pin_drive_t      scl_out
);
  import smbus_ctrl_pkg::*;

  logic [1:0] sda_s_q, scl_s_q;
  logic       sda_q, scl_q;
  logic [7:0] ctrl_q;
  logic       busy_q, en_q, sta_q, sto_q, si_q, aa_q, fte_q, toe_q;
  mstate_t    st_q;
  logic [CNT_W-1:0] idle_cnt_q, dly_cnt_q, half_q;
  logic       addressed_q, byte_done_q, scl_drv_q, sda_drv_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q, status_q;
  logic       start_det, stop_det, ctrl_wr, si_set, free_to, idle_free;
  logic [7:0] free_lim;
  logic       rose_scl, ack_phase;

  // two-flop synchronisers for the bus lines
  always_ff @(posedge clk_in)
  begin
    sda_s_q <= {sda_s_q[0], sda_in};
    scl_s_q <= {scl_s_q[0], scl_in};
    sda_q   <= sda_s_q[1];
    scl_q   <= scl_s_q[1];
  end

  // bus condition detection on synchronised lines
  assign start_det = scl_q && scl_s_q[1] && sda_q && !sda_s_q[1];
  assign stop_det  = scl_q && scl_s_q[1] && !sda_q && sda_s_q[1];
  assign rose_scl  = !scl_q && scl_s_q[1];
  assign ctrl_wr   = sfr_wr_in && (sfr_addr_in == CTRL_OFFSET);
  assign ack_phase = (bit_q == 4'd8);

  // free timeout limit from clock rate setting, in microseconds
  assign free_lim  = clock_rate_reg_in;
  assign free_to   = fte_q && (idle_cnt_q >= CNT_W'(free_lim) * CNT_W'(CLK_MHZ));
  assign idle_free = (idle_cnt_q >= CNT_W'(IDLE_FREE_CYC));

  // idle counter: both lines high
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !en_q || !scl_q || !sda_q)
      idle_cnt_q <= '0;
    else if (!idle_cnt_q[CNT_W-1])
      idle_cnt_q <= idle_cnt_q + 1'b1;
  end

  // bus busy tracking
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !en_q)
      busy_q <= 1'b0;
    else if (start_det)
      busy_q <= 1'b1;
    else if (stop_det || free_to || idle_free)
      busy_q <= 1'b0;
  end

  // event flag: set wins over the software clear
  assign si_set = ((st_q == M_XFER) || (st_q == M_SLAVE)) && rose_scl
                  && ack_phase && !si_q && (st_q == M_XFER || addressed_q)
                  || (st_q == M_START) && half_q == '0;
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      si_q <= 1'b0;
    else if (si_set && en_q)
      si_q <= 1'b1;
    else if (ctrl_wr)
      si_q <= sfr_wdata_in[BIT_EVENT];
  end

  // control register software fields
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      en_q  <= CTRL_RESET[BIT_ENABLE];
      sta_q <= CTRL_RESET[BIT_START];
      aa_q  <= CTRL_RESET[BIT_ACK];
      fte_q <= CTRL_RESET[BIT_FREE_TO];
      toe_q <= CTRL_RESET[BIT_LOW_TO];
    end
    else if (ctrl_wr)
    begin
      en_q  <= sfr_wdata_in[BIT_ENABLE];
      sta_q <= sfr_wdata_in[BIT_START];
      aa_q  <= sfr_wdata_in[BIT_ACK];
      fte_q <= sfr_wdata_in[BIT_FREE_TO];
      toe_q <= sfr_wdata_in[BIT_LOW_TO];
    end
  end

  // stop request: hardware clears it on a bus stop or slave recovery
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      sto_q <= CTRL_RESET[BIT_STOP];
    else if (stop_det || (st_q == M_SLAVE && sto_q && !ctrl_wr))
      sto_q <= 1'b0;
    else if (ctrl_wr)
      sto_q <= sfr_wdata_in[BIT_STOP];
  end

  // master and slave sequencing
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !en_q)
    begin
      st_q        <= M_IDLE;
      dly_cnt_q   <= '0;
      half_q      <= '0;
      bit_q       <= 4'd0;
      byte_done_q <= 1'b0;
      addressed_q <= 1'b0;
      scl_drv_q   <= 1'b0;
      sda_drv_q   <= 1'b0;
      shift_q     <= 8'h00;
      status_q    <= ST_IDLE;
    end
    else
    begin
      case (st_q)
        M_IDLE:
        begin
          sda_drv_q <= 1'b0;
          scl_drv_q <= 1'b0;
          bit_q     <= 4'd0;
          if (sta_q && !busy_q)
          begin
            st_q   <= M_START;
            half_q <= CNT_W'(HALF_BIT_CYC);
          end
          else if (sta_q)
          begin
            st_q      <= M_WAIT;
            dly_cnt_q <= '0;
          end
          else if (start_det)
          begin
            st_q        <= M_SLAVE;
            addressed_q <= 1'b0;
          end
        end
        M_WAIT:
        begin
          if (busy_q)
            dly_cnt_q <= '0;
          else if (dly_cnt_q >= CNT_W'(START_DELAY_CYC) || free_to)
          begin
            st_q   <= M_START;
            half_q <= CNT_W'(HALF_BIT_CYC);
          end
          else
            dly_cnt_q <= dly_cnt_q + 1'b1;
        end
        M_START:
        begin
          if (half_q != '0)
          begin
            half_q    <= half_q - 1'b1;
            scl_drv_q <= 1'b0;
            // a repeated start first keeps sda released under a high clock
            sda_drv_q <= !byte_done_q
                         || (half_q <= CNT_W'(HALF_BIT_CYC / 2));
          end
          else
          begin
            scl_drv_q   <= 1'b1;
            status_q    <= byte_done_q ? ST_RESTART : ST_START_SENT;
            st_q        <= M_XFER;
            bit_q       <= 4'd8;
            shift_q     <= shift_data_reg_in;
          end
        end
        M_XFER:
        begin
          if (si_q)
          begin
            scl_drv_q <= 1'b1;
            half_q    <= CNT_W'(HALF_BIT_CYC);
            if (ctrl_wr && !sfr_wdata_in[BIT_EVENT] && bit_q == 4'd8)
            begin
              bit_q   <= 4'd0;
              shift_q <= shift_data_reg_in;
            end
          end
          else if (sto_q)
          begin
            st_q      <= M_STOP;
            sda_drv_q <= 1'b1;
            scl_drv_q <= 1'b0;
            half_q    <= CNT_W'(HALF_BIT_CYC);
          end
          else if (sta_q && byte_done_q)
          begin
            st_q      <= M_START;
            sda_drv_q <= 1'b0;
            scl_drv_q <= 1'b1;
            half_q    <= CNT_W'(HALF_BIT_CYC);
          end
          else
          begin
            // data only changes while the clock is held low
            if (scl_drv_q)
              sda_drv_q <= !ack_phase && !shift_q[7];
            if (half_q != '0)
              half_q <= half_q - 1'b1;
            else
            begin
              half_q    <= CNT_W'(HALF_BIT_CYC);
              scl_drv_q <= !scl_drv_q;
            end
            if (rose_scl && !ack_phase)
            begin
              shift_q <= {shift_q[6:0], sda_q};
              bit_q   <= bit_q + 4'd1;
              if (bit_q == 4'd7)
              begin
                byte_done_q <= 1'b1;
                status_q    <= ST_DATA_ACK;
              end
            end
          end
        end
        M_STOP:
        begin
          if (half_q != '0)
            half_q <= half_q - 1'b1;
          else
          begin
            sda_drv_q   <= 1'b0;
            byte_done_q <= 1'b0;
            st_q        <= M_IDLE;
            status_q    <= ST_IDLE;
          end
        end
        M_SLAVE:
        begin
          scl_drv_q <= si_q;
          if (sto_q || stop_det)
          begin
            st_q        <= sta_q ? M_WAIT : M_IDLE;
            dly_cnt_q   <= '0;
            addressed_q <= 1'b0;
            sda_drv_q   <= 1'b0;
            status_q    <= ST_IDLE;
          end
          else if (rose_scl && !ack_phase)
          begin
            shift_q <= {shift_q[6:0], sda_q};
            bit_q   <= bit_q + 4'd1;
            if (bit_q == 4'd7 && !addressed_q && aa_q
                && ({shift_q[6:0], 1'b0} == {own_address_reg_in[7:1], 1'b0}
                || (shift_q[6:0] == 7'h00 && own_address_reg_in[0])))
            begin
              addressed_q <= 1'b1;
              status_q    <= ST_SLV_ADDR;
            end
            else if (bit_q == 4'd7 && addressed_q)
              status_q <= ST_SLV_DATA;
          end
          else if (ack_phase && !scl_q && !si_q)
            sda_drv_q <= addressed_q && aa_q;
          else if (ack_phase && si_q && ctrl_wr
                   && !sfr_wdata_in[BIT_EVENT])
          begin
            bit_q     <= 4'd0;
            sda_drv_q <= 1'b0;
          end
          else if (rose_scl && ack_phase && !addressed_q)
          begin
            bit_q     <= 4'd0;
            sda_drv_q <= 1'b0;
          end
        end
        default:
          st_q <= M_IDLE;
      endcase
    end
  end

  // register outputs and pin drives
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sfr_rdata_out       <= CTRL_RESET;
      status_code_reg_out <= ST_IDLE;
      rx_data_out         <= 8'h00;
      irq_out             <= 1'b0;
      low_count_out       <= 1'b0;
      sda_out             <= '0;
      scl_out             <= '0;
    end
    else
    begin
      sfr_rdata_out <= {busy_q, en_q, sta_q, sto_q, si_q, aa_q, fte_q,
                        toe_q};
      status_code_reg_out <= {status_q[7:3], 3'b000};
      if (si_q)
        rx_data_out <= shift_q;
      irq_out       <= si_q && irq_enable_in;
      low_count_out <= toe_q && low_timer_run_in && !scl_q;
      sda_out.o     <= 1'b0;
      scl_out.o     <= 1'b0;
      sda_out.oe    <= en_q && sda_drv_q;
      scl_out.oe    <= en_q && (scl_drv_q || si_q);
    end
  end
endmodule

`default_nettype wire

// ===== smbus_ctrl_asserts.sv
// checker: timing relations on the control logic ports
// assumes it is bound onto every smbus_control_logic instance
`timescale 1ns/1ps
`default_nettype none
module smbus_ctrl_asserts
  import smbus_ctrl_pkg::*;
(
  // clock, reset and register access
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  // status, events and pins
  input wire logic [7:0] status_code_reg_out,
  input wire logic       irq_enable_in,
  input wire logic       low_timer_run_in,
  input wire logic       irq_out,
  input wire logic       low_count_out,
  input wire logic       sda_in,
  input wire logic       scl_in,
  input wire pin_drive_t sda_out,
  input wire pin_drive_t scl_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // bus conditions on the raw pins while enabled
  sequence s_bus_start;
    scl_in && $fell(sda_in) && sfr_rdata_out[BIT_ENABLE];
  endsequence
  sequence s_bus_stop;
    scl_in && $rose(sda_in) && sfr_rdata_out[BIT_ENABLE];
  endsequence
  // start request written while idle on a free bus
  sequence s_start_wr;
    sfr_wr_in && sfr_addr_in == CTRL_OFFSET && sfr_wdata_in[6:4] == 3'h6
      && !sfr_rdata_out[BIT_BUSY] && !sfr_rdata_out[BIT_START]
      && !sfr_rdata_out[BIT_EVENT] && sda_in && scl_in;
  endsequence
  // properties
  property p_flag_sw;
    $fell(sfr_rdata_out[BIT_EVENT]) |-> $past(sfr_wr_in
      && sfr_addr_in == CTRL_OFFSET && !sfr_wdata_in[BIT_EVENT], 2);
  endproperty
  property p_off_release;
    !sfr_rdata_out[BIT_ENABLE] [*2] |-> !sda_out.oe && !scl_out.oe;
  endproperty
  property p_start_free;
    s_start_wr |-> ##[1:4] sda_out.oe;
  endproperty
  property p_stretch;
    sfr_rdata_out[BIT_EVENT] && $past(sfr_rdata_out[BIT_EVENT])
      && sfr_rdata_out[BIT_ENABLE] |-> scl_out.oe;
  endproperty
  property p_irq;
    irq_out == (sfr_rdata_out[BIT_EVENT] && $past(irq_enable_in));
  endproperty
  property p_codes;
    status_code_reg_out[2:0] == 3'h0;
  endproperty
  property p_stop_clr;
    s_bus_stop |-> ##[1:8] !sfr_rdata_out[BIT_STOP];
  endproperty
  property p_busy_start;
    s_bus_start |-> ##[1:8] sfr_rdata_out[BIT_BUSY];
  endproperty
  property p_low_cnt;
    low_count_out |-> sfr_rdata_out[BIT_LOW_TO] && $past(low_timer_run_in)
      && !($past(scl_in, 2) && $past(scl_in, 3) && $past(scl_in, 4));
  endproperty
  a_flag_sw: assert property (p_flag_sw)
    else $error("event flag fell without a clearing write");
  a_off_release: assert property (p_off_release)
    else $error("bus line driven while disabled");
  a_start_free: assert property (p_start_free)
    else $error("no start on a free bus");
  a_stretch: assert property (p_stretch)
    else $error("scl not held while flag set");
  a_irq: assert property (p_irq)
    else $error("irq does not follow the flag");
  a_codes: assert property (p_codes)
    else $error("status code not a multiple of eight");
  a_stop_clr: assert property (p_stop_clr)
    else $error("stop bit kept after bus stop");
  a_busy_start: assert property (p_busy_start)
    else $error("busy not set after bus start");
  a_low_cnt: assert property (p_low_cnt)
    else $error("low count without scl low and enables");
endmodule

bind smbus_control_logic smbus_ctrl_asserts u_chk (.clk_in, .rst_n_in,
  .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .sfr_rdata_out,
  .status_code_reg_out, .irq_enable_in, .low_timer_run_in, .irq_out,
  .low_count_out, .sda_in, .scl_in, .sda_out, .scl_out);
`default_nettype wire

// ===== smbus_far_end.sv
// far-end bus party: other masters and slaves on sda/scl
// assumes pull-ups on both lines and open-drain drives everywhere
`timescale 1ns/1ps
`default_nettype none
module smbus_far_end
  import smbus_ctrl_pkg::*;
(
  // clock and device drives
  input  wire logic       clk_in,
  input  wire pin_drive_t dev_sda_in,
  input  wire pin_drive_t dev_scl_in,
  // resolved lines
  output logic            sda_line_out,
  output logic            scl_line_out
);
  logic sda_pull = 1'b0;
  logic scl_pull = 1'b0;
  // pull-ups: a line is low while any party pulls it
  assign sda_line_out = !(sda_pull || dev_sda_in.oe);
  assign scl_line_out = !(scl_pull || dev_scl_in.oe);
  // move both pulls a quarter bit later
  task automatic step(input logic s, input logic c);
    repeat (HALF_BIT_CYC / 2) @(posedge clk_in);
    #1;
    sda_pull = s;
    scl_pull = c;
  endtask
  // start: sda falls while scl high
  task automatic bus_start();
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  // stop: sda rises while scl high
  task automatic bus_stop();
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  // one byte msb first, then the ack clock is sampled
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic [8:0] v;
    v = {b, 1'b1};
    for (int i = 8; i >= 0; i--)
    begin
      step(!v[i], 1'b1);
      step(!v[i], 1'b0);
      ack = !sda_line_out;
    end
    step(1'b0, 1'b1);
  endtask
endmodule
`default_nettype wire

// ===== tb.sv
// testbench: drives the control register and the bus, judges the ports
// assumes the far-end model resolves both open-drain lines
`timescale 1ns/1ps
`default_nettype none
module tb;
  import smbus_ctrl_pkg::*;
  logic       clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       wr = 1'b0;
  logic       irq_en = 1'b0;
  logic       run = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, status, rxd;
  logic       irq, low_cnt, sda, scl, ack;
  pin_drive_t sda_d, scl_d;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         n_stops = 0;
  int         cyc = 0;
  int         n;
  // design and far end
  smbus_control_logic u_dut (.clk_in, .rst_n_in, .sfr_addr_in(addr),
    .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
    .clock_rate_reg_in(8'h3c), .own_address_reg_in(8'ha6),
    .shift_data_reg_in(8'h5a), .irq_enable_in(irq_en),
    .low_timer_run_in(run), .status_code_reg_out(status),
    .rx_data_out(rxd), .irq_out(irq), .low_count_out(low_cnt),
    .sda_in(sda), .scl_in(scl), .sda_out(sda_d), .scl_out(scl_d));
  smbus_far_end u_far (.clk_in, .dev_sda_in(sda_d), .dev_scl_in(scl_d),
    .sda_line_out(sda), .scl_line_out(scl));
  // system clock, 10 ns period
  initial
  begin
    forever #5 clk_in = ~clk_in;
  end
  // count stop conditions on the lines
  always @(posedge sda)
  begin
    if (scl)
      n_stops++;
  end
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one write pulse; readback settled on return
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    tick();
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick();
    wr = 1'b0;
    repeat (2) tick();
  endtask
  task automatic wait_flag();
    for (n = 0; n < 3000 && rdata[BIT_EVENT] !== 1'b1; n++)
      tick();
  endtask
  // master stop, judged on the lines and the stop bit
  task automatic stop_master();
    int s;
    s = n_stops;
    wr_reg(CTRL_OFFSET, 8'h54);
    for (n = 0; n < 3000 && rdata[BIT_STOP] !== 1'b0; n++)
      tick();
    repeat (8) tick();
    check("stop seen", 8'(s + 1), 8'(n_stops));
    check("stop bit", 8'h00, 8'(rdata[BIT_STOP]));
    check("busy off", 8'h00, 8'(rdata[BIT_BUSY]));
  endtask
  task automatic t_regs();
    check("ctrl reset", CTRL_RESET, rdata);
    check("status reset", ST_IDLE, status);
    wr_reg(CTRL_OFFSET, 8'h87);
    check("busy read only", 8'h07, rdata);
    wr_reg(8'hc1, 8'h00);
    check("other address", 8'h07, rdata);
    wr_reg(CTRL_OFFSET, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_master();
    logic [7:0] b;
    int s;
    irq_en = 1'b1;
    wr_reg(CTRL_OFFSET, 8'h44);
    wr_reg(CTRL_OFFSET, 8'h64);
    repeat (2) tick();
    check("start lines", 8'h01, {6'h00, sda, scl});
    wait_flag();
    check("start code", ST_START_SENT, status);
    check("irq", 8'h01, 8'(irq));
    repeat (300) tick();
    check("flag held", 8'h01, 8'(rdata[BIT_EVENT]));
    check("scl stretched", 8'h00, 8'(scl));
    wr_reg(CTRL_OFFSET, 8'h44);
    check("irq cleared", 8'h00, 8'(irq));
    for (int i = 7; i >= 0; i--)
    begin
      for (n = 0; n < 2000 && scl !== 1'b0; n++)
        tick();
      for (n = 0; n < 2000 && scl !== 1'b1; n++)
        tick();
      b[i] = sda;
    end
    check("msb first", 8'h5a, b);
    wait_flag();
    s = n_stops;
    wr_reg(CTRL_OFFSET, 8'h64);
    wait_flag();
    check("restart code", ST_RESTART, status);
    check("no stop", 8'(s), 8'(n_stops));
    stop_master();
    $display("test master done");
  endtask
  task automatic t_busy();
    irq_en = 1'b0;
    run = 1'b1;
    wr_reg(CTRL_OFFSET, 8'h45);
    u_far.bus_start();
    repeat (8) tick();
    check("busy other", 8'h01, 8'(rdata[BIT_BUSY]));
    check("low count", 8'h01, 8'(low_cnt));
    wr_reg(CTRL_OFFSET, 8'h65);
    repeat (1000) tick();
    check("start held", 8'h00, 8'(sda_d.oe));
    u_far.bus_stop();
    check("low idle", 8'h00, 8'(low_cnt));
    for (n = 0; n < 900 && sda_d.oe !== 1'b1; n++)
      tick();
    check("start delay", 8'h01, 8'(n >= START_DELAY_CYC - 5
      && n <= START_DELAY_CYC + 10));
    wait_flag();
    stop_master();
    $display("test busy done");
  endtask
  task automatic t_slave();
    int s;
    wr_reg(CTRL_OFFSET, 8'h44);
    u_far.bus_start();
    u_far.send_byte(8'ha6, ack);
    check("ack on", 8'h01, 8'(ack));
    wait_flag();
    check("slave code", ST_SLV_ADDR, status);
    check("rx byte", 8'ha6, rxd);
    s = n_stops;
    wr_reg(CTRL_OFFSET, 8'h54);
    repeat (4) tick();
    check("recover", 8'h00, {4'h0, rdata[BIT_STOP], rdata[BIT_EVENT],
      sda_d.oe, scl_d.oe});
    check("no bus stop", 8'(s), 8'(n_stops));
    u_far.bus_stop();
    wr_reg(CTRL_OFFSET, 8'h40);
    u_far.bus_start();
    u_far.send_byte(8'ha6, ack);
    repeat (8) tick();
    check("nack", 8'h00, 8'(ack));
    check("ignored", 8'h00, 8'(rdata[BIT_EVENT]));
    u_far.bus_stop();
    $display("test slave done");
  endtask
  task automatic t_off();
    wr_reg(CTRL_OFFSET, 8'h64);
    wait_flag();
    wr_reg(CTRL_OFFSET, 8'h00);
    check("released", 8'h00, {6'h00, sda_d.oe, scl_d.oe});
    check("idle code", ST_IDLE, status);
    wr_reg(CTRL_OFFSET, 8'h44);
    check("re-enabled", 8'h44, rdata);
    $display("test off done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // cycle ceiling against a hung bus
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      $display("timeout at cycle %0d", cyc);
      end_sim();
    end
  end
  // reset, then the scenarios in order
  initial
  begin
    repeat (16) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    t_regs();
    t_master();
    t_busy();
    t_slave();
    t_off();
    end_sim();
  end
endmodule
`default_nettype wire
